// ### rtl/dpc_params.svh
// Constants for the dual pulse counter channel.
// Assumes a 10 MHz clock and an APB register port.
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH
`define DPC_A_CTRL 8'h00
`define DPC_A_STEP 8'h04
`define DPC_A_DIV 8'h08
`define DPC_A_ML1 8'h0C
`define DPC_A_ML2 8'h10
`define DPC_A_DL1 8'h14
`define DPC_A_DL2 8'h18
`define DPC_A_OBJ 8'h1C
`define DPC_A_MVAL 8'h20
`define DPC_A_DVAL 8'h24
`define DPC_A_STAT 8'h28
`define DPC_A_CYC 8'h2C
`define DPC_A_CRST 8'h30
`define DPC_B_DCEN 0
`define DPC_B_STOPM 1
`define DPC_B_REV 2
`define DPC_B_INIM 3
`define DPC_B_INID 4
`define DPC_B_CHGM 5
`define DPC_B_CHGD 6
`define DPC_B_CYCM 7
`define DPC_B_CYCD 8
`define DPC_CTRL_RST 32'h0000_0000
`define DPC_STEP_MAX 10000
`define DPC_DIV_MAX 10000
`define DPC_DL2_RST 32'h0000_00FF
`define DPC_OBJ_BASE 10
`define DPC_CLK_HZ 10000000
`define DPC_TICK_MS 1
`define DPC_TICK_CYC (`DPC_CLK_HZ / 1000 * `DPC_TICK_MS)
`define DPC_SDLY_MS 100
`endif

// ### rtl/dpc_pkg.sv
// Types shared by the dual pulse counter channel.
// Assumes dpc_params.svh supplies the numeric constants.
package dpc_pkg;
  typedef enum logic [2:0] {
    DPC_U8 = 3'b000,
    DPC_S8 = 3'b001,
    DPC_U16 = 3'b010,
    DPC_S16 = 3'b011,
    DPC_S32 = 3'b100
  } dpc_type_t;
  typedef struct packed {
    logic [6:0] obj;
    logic [2:0] len;
    logic [31:0] data;
  } dpc_tel_t;
endpackage : dpc_pkg

// ### rtl/dpc_top.sv
// One pulse counter channel: main and difference counters, object port.
// Assumes qualified input pulses arrive as one-cycle strobes on clk.
//
// Behaviour
// - Each counter pulse adds a signed step within +-10000, default 1.
// - After recovery or reset, send enabled counter values once delay expires.
// - Each counter may send on change and cyclically.
// - Difference counter width selectable: u8, s8, u16, s16, s32.
// - Pulse beyond a limit loads opposite limit; counting continues.
// - Larger limit is the upper bound regardless of order.
// - Difference limits default to 0 and top of range.
// - Circular: below lower loads upper, above upper loads lower.
// - Stop mode halts at crossing until configuration reset.
// - Difference counter follows main direction by default.
// - Configuration option inverts difference counting direction.
// - Channel owns ten object numbers, base ten plus ten per channel.
// - Block object 1 disables input, 0 enables; objects still sent.
// - While blocked, pending pulse qualification waits are suspended.
// - On unblock, a changed input state is processed at once.
// - Block leaves manual operation working.
// - Main value object sent at 1, 2 or 4 bytes by type.
// - Request object 1 sends counter values; 0 does nothing.
// - Main counter crossing sends 1 on its limit flag object.
// - Difference counter crossing sends 1 on its limit flag object.
// - Reverse object 1 inverts difference direction, 0 keeps it.
// - Reset object 1 returns difference counter to start value.
// - Stop object 1 halts difference counter, 0 runs it.
// - Blocked input counts no pulses in either counter.
// - Counter pulse after 1 to 10000 qualified input pulses.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "dpc_params.svh"
module dpc_top
  import dpc_pkg::*;
#(
  parameter int CHANNEL = 0,
  parameter int TICK_CYC = `DPC_TICK_CYC,
  parameter int SDLY_MS = `DPC_SDLY_MS
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_pulse,
  input wire logic in_level,
  input wire logic manual_pulse,
  input wire logic bus_recover,
  output dpc_tel_t tel,
  output logic tel_valid,
  input wire logic tel_ready
);
  localparam logic [6:0] OBJ0 = 7'(`DPC_OBJ_BASE + 10 * CHANNEL);
  localparam int TW = $clog2(TICK_CYC);

  // Type bounds, used by both counters
  function automatic logic signed [33:0] tmax(input logic [2:0] t);
    unique case (t)
      DPC_U8: tmax = 34'sh0_0000_00FF;
      DPC_S8: tmax = 34'sh0_0000_007F;
      DPC_U16: tmax = 34'sh0_0000_FFFF;
      DPC_S16: tmax = 34'sh0_0000_7FFF;
      default: tmax = 34'sh0_7FFF_FFFF;
    endcase
  endfunction : tmax

  function automatic logic signed [33:0] tmin(input logic [2:0] t);
    unique case (t)
      DPC_S8: tmin = -34'sh0_0000_0080;
      DPC_S16: tmin = -34'sh0_0000_8000;
      DPC_S32: tmin = -34'sh0_8000_0000;
      default: tmin = 34'sh0_0000_0000;
    endcase
  endfunction : tmin

  // One step with wrap; bit 32 flags a crossing
  function automatic logic [32:0] stepf(input logic [31:0] v,
    input logic signed [15:0] s, input logic [31:0] la,
    input logic [31:0] lb, input logic [2:0] t);
    logic signed [33:0] a, b, hi, lo, sum;
    a = 34'(signed'(la));
    b = 34'(signed'(lb));
    hi = (a > b) ? a : b;
    lo = (a > b) ? b : a;
    if (hi > tmax(t)) hi = tmax(t);
    if (lo < tmin(t)) lo = tmin(t);
    sum = 34'(signed'(v)) + 34'(s);
    if (sum > hi) stepf = {1'b1, lo[31:0]};
    else if (sum < lo) stepf = {1'b1, hi[31:0]};
    else stepf = {1'b0, sum[31:0]};
  endfunction : stepf

  function automatic logic [2:0] tlen(input logic [2:0] t);
    tlen = (t == DPC_S32) ? 3'h4 : (t >= DPC_U16) ? 3'h2 : 3'h1;
  endfunction : tlen

  logic [31:0] ctrl_ff, ml1_ff, ml2_ff, dl1_ff, dl2_ff, cyc_ff;
  logic signed [15:0] step_ff;
  logic [13:0] div_ff, pcnt_ff;
  logic [31:0] mval_ff, dval_ff;
  logic blk_ff, rev_ff, stop_ff, halt_ff, lvl_ff;
  logic cnt_ff;
  logic [3:0] pend_ff;
  logic [31:0] prdata_ff;
  logic [15:0] sdly_ff;
  logic [TW-1:0] tick_ff;
  logic [15:0] cm_ff, cd_ff;
  dpc_tel_t tel_ff;
  logic tv_ff;

  logic wr, rd, mapped, ow, crst, tick, sdone;
  logic [32:0] mnx, dnx;
  logic signed [15:0] dstep;
  logic dgo, lvl_chg;
  logic [2:0] mt, dt;

  assign mt = ctrl_ff[12:10];
  assign dt = ctrl_ff[15:13];
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign ow = wr && paddr == `DPC_A_OBJ;
  assign crst = wr && paddr == `DPC_A_CRST && pwdata[0];

  // Known offsets answer, others give an error
  always_comb
  begin
    unique case (paddr)
      `DPC_A_CTRL, `DPC_A_STEP, `DPC_A_DIV, `DPC_A_ML1, `DPC_A_ML2,
      `DPC_A_DL1, `DPC_A_DL2, `DPC_A_OBJ, `DPC_A_MVAL, `DPC_A_DVAL,
      `DPC_A_STAT, `DPC_A_CYC, `DPC_A_CRST: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait state: answer in the access cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) prdata_ff <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (paddr)
        `DPC_A_CTRL: prdata_ff <= ctrl_ff;
        `DPC_A_STEP: prdata_ff <= 32'(step_ff);
        `DPC_A_DIV: prdata_ff <= {18'h0_0000, div_ff};
        `DPC_A_ML1: prdata_ff <= ml1_ff;
        `DPC_A_ML2: prdata_ff <= ml2_ff;
        `DPC_A_DL1: prdata_ff <= dl1_ff;
        `DPC_A_DL2: prdata_ff <= dl2_ff;
        `DPC_A_MVAL: prdata_ff <= mval_ff;
        `DPC_A_DVAL: prdata_ff <= dval_ff;
        `DPC_A_STAT: prdata_ff <= {24'h00_0000, pend_ff, halt_ff,
                                   stop_ff, rev_ff, blk_ff};
        `DPC_A_CYC: prdata_ff <= cyc_ff;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers; step and divider clamped on write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= `DPC_CTRL_RST;
      step_ff <= 16'sh0001;
      div_ff <= 14'h0001;
      ml1_ff <= 32'h0000_0000;
      ml2_ff <= 32'h0000_00FF;
      dl1_ff <= 32'h0000_0000;
      dl2_ff <= `DPC_DL2_RST;
      cyc_ff <= 32'h0000_0000;
    end
    else if (wr)
    begin
      unique case (paddr)
        `DPC_A_CTRL: ctrl_ff <= pwdata;
        `DPC_A_STEP:
        begin
          if ($signed(pwdata) > `DPC_STEP_MAX) step_ff <= 16'sh2710;
          else if ($signed(pwdata) < -`DPC_STEP_MAX) step_ff <= -16'sh2710;
          else step_ff <= pwdata[15:0];
        end
        `DPC_A_DIV:
        begin
          if (pwdata == 32'h0000_0000) div_ff <= 14'h0001;
          else if (pwdata > `DPC_DIV_MAX) div_ff <= 14'h2710;
          else div_ff <= pwdata[13:0];
        end
        `DPC_A_ML1: ml1_ff <= pwdata;
        `DPC_A_ML2: ml2_ff <= pwdata;
        `DPC_A_DL1: dl1_ff <= pwdata;
        `DPC_A_DL2: dl2_ff <= pwdata;
        `DPC_A_CYC: cyc_ff <= pwdata;
        default: ;
      endcase
    end
  end

  // Object writes: block, reverse and stop are held levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blk_ff <= 1'b0;
      rev_ff <= 1'b0;
      stop_ff <= 1'b0;
    end
    else if (ow)
    begin
      if (pwdata[6:0] == OBJ0) blk_ff <= pwdata[8];
      if (pwdata[6:0] == OBJ0 + 7'h06) rev_ff <= pwdata[8];
      if (pwdata[6:0] == OBJ0 + 7'h08) stop_ff <= pwdata[8];
    end
  end

  // Level seen at block time; compared again on release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) lvl_ff <= 1'b0;
    else if (!blk_ff) lvl_ff <= in_level;
  end
  assign lvl_chg = blk_ff && ow && pwdata[6:0] == OBJ0 && !pwdata[8]
                   && in_level != lvl_ff;

  // Prescaler holds its count while blocked rather than losing it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcnt_ff <= 14'h0000;
      cnt_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= 1'b0;
      if (manual_pulse) cnt_ff <= 1'b1;
      else if ((in_pulse && !blk_ff) || lvl_chg)
      begin
        if (pcnt_ff + 14'h0001 >= div_ff)
        begin
          pcnt_ff <= 14'h0000;
          cnt_ff <= 1'b1;
        end
        else pcnt_ff <= pcnt_ff + 14'h0001;
      end
    end
  end

  // Difference direction: config inversion xor reverse object
  assign dstep = (ctrl_ff[`DPC_B_REV] ^ rev_ff) ? -step_ff : step_ff;
  assign mnx = stepf(mval_ff, step_ff, ml1_ff, ml2_ff, mt);
  assign dnx = stepf(dval_ff, dstep, dl1_ff, dl2_ff, dt);
  assign dgo = cnt_ff && ctrl_ff[`DPC_B_DCEN] && !stop_ff && !halt_ff;

  // Main counter; one update per strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) mval_ff <= 32'h0000_0000;
    else if (crst) mval_ff <= ml1_ff;
    else if (cnt_ff) mval_ff <= mnx[31:0];
  end

  // Difference counter, start value is the first limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) dval_ff <= 32'h0000_0000;
    else if (crst || (ow && pwdata[6:0] == OBJ0 + 7'h07 && pwdata[8]))
      dval_ff <= dl1_ff;
    else if (dgo && !(dnx[32] && ctrl_ff[`DPC_B_STOPM]))
      dval_ff <= dnx[31:0];
  end

  // Stop mode latch, released only by configuration reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) halt_ff <= 1'b0;
    else if (crst) halt_ff <= 1'b0;
    else if (dgo && dnx[32] && ctrl_ff[`DPC_B_STOPM]) halt_ff <= 1'b1;
  end

  // Millisecond tick for the send delay and cyclic timers
  assign tick = tick_ff == TW'(TICK_CYC - 1);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) tick_ff <= '0;
    else if (tick) tick_ff <= '0;
    else tick_ff <= tick_ff + TW'(1);
  end

  // Send delay restarts on bus recovery or configuration reset
  assign sdone = tick && sdly_ff == 16'h0001;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) sdly_ff <= 16'(SDLY_MS);
    else if (bus_recover || crst) sdly_ff <= 16'(SDLY_MS);
    else if (tick && sdly_ff != 16'h0000) sdly_ff <= sdly_ff - 16'h0001;
  end

  // Cyclic timers, period in ms per counter; zero period disables
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cm_ff <= 16'h0000;
      cd_ff <= 16'h0000;
    end
    else if (tick)
    begin
      cm_ff <= (cm_ff + 16'h0001 >= cyc_ff[15:0]) ? 16'h0000 : cm_ff + 16'h0001;
      cd_ff <= (cd_ff + 16'h0001 >= cyc_ff[31:16]) ? 16'h0000 : cd_ff + 16'h0001;
    end
  end

  logic cyc_m, cyc_d, req, snd;
  logic [3:0] setp, clrp;
  assign cyc_m = tick && cyc_ff[15:0] != 16'h0000
                 && cm_ff + 16'h0001 >= cyc_ff[15:0];
  assign cyc_d = tick && cyc_ff[31:16] != 16'h0000
                 && cd_ff + 16'h0001 >= cyc_ff[31:16];
  assign req = ow && pwdata[6:0] == OBJ0 + 7'h03 && pwdata[8];

  // Pending sends: 0 main value, 1 diff value, 2 main flag, 3 diff flag
  always_comb
  begin
    setp = 4'h0;
    setp[0] = req || (sdone && ctrl_ff[`DPC_B_INIM])
              || (ctrl_ff[`DPC_B_CHGM] && cnt_ff && mnx[31:0] != mval_ff)
              || (ctrl_ff[`DPC_B_CYCM] && cyc_m);
    setp[1] = ctrl_ff[`DPC_B_DCEN] && (req || (sdone && ctrl_ff[`DPC_B_INID])
              || (ctrl_ff[`DPC_B_CHGD] && dgo && dnx[31:0] != dval_ff)
              || (ctrl_ff[`DPC_B_CYCD] && cyc_d));
    setp[2] = cnt_ff && mnx[32];
    setp[3] = dgo && dnx[32];
  end

  // Lowest pending slot goes out first
  assign snd = !tv_ff && pend_ff != 4'h0;
  always_comb
  begin
    clrp = 4'h0;
    if (snd)
    begin
      if (pend_ff[0]) clrp[0] = 1'b1;
      else if (pend_ff[1]) clrp[1] = 1'b1;
      else if (pend_ff[2]) clrp[2] = 1'b1;
      else clrp[3] = 1'b1;
    end
  end

  // A new event in the send cycle stays pending
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) pend_ff <= 4'h0;
    else pend_ff <= (pend_ff & ~clrp) | setp;
  end

  // Telegram holds until the link takes it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tv_ff <= 1'b0;
      tel_ff <= '0;
    end
    else if (tv_ff)
    begin
      if (tel_ready) tv_ff <= 1'b0;
    end
    else if (snd)
    begin
      tv_ff <= 1'b1;
      if (clrp[0]) tel_ff <= '{OBJ0 + 7'h01, tlen(mt), mval_ff};
      else if (clrp[1]) tel_ff <= '{OBJ0 + 7'h02, tlen(dt), dval_ff};
      else if (clrp[2]) tel_ff <= '{OBJ0 + 7'h04, 3'h1, 32'h0000_0001};
      else tel_ff <= '{OBJ0 + 7'h05, 3'h1, 32'h0000_0001};
    end
  end
  assign tel = tel_ff;
  assign tel_valid = tv_ff;

  // Checks kept beside the logic
  step_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    step_ff <= 16'sh2710 && step_ff >= -16'sh2710)
    else $error("step out of range");
  div_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    div_ff >= 14'h0001 && div_ff <= 14'h2710)
    else $error("divider out of range");
  blocked_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    blk_ff && !manual_pulse && !ow |=> !cnt_ff)
    else $error("blocked input made a count");
  strobe_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_ff && !manual_pulse |=> !cnt_ff)
    else $error("counter strobe wider than one cycle");
  halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    halt_ff && !crst && !ow |=> $stable(dval_ff))
    else $error("halted counter moved");
  main_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_ff && mnx[32] |=> pend_ff[2] || (tv_ff && tel_ff.obj == OBJ0 + 7'h04))
    else $error("main crossing not flagged");
  request_a: assert property (@(posedge clk) disable iff (!rst_n)
    req |=> pend_ff[0] || tv_ff)
    else $error("request not served");
  dir_rev_a: assert property (@(posedge clk) disable iff (!rst_n)
    dgo && !dnx[32] && !crst && !ow && (ctrl_ff[`DPC_B_REV] != rev_ff)
    |=> dval_ff == $past(dval_ff) - 32'(signed'($past(step_ff))))
    else $error("difference direction wrong");
  obj_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    tv_ff |-> tel_ff.obj > OBJ0 && tel_ff.obj < OBJ0 + 7'h0A)
    else $error("object number outside channel block");
  wrap_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_ff && !crst && mnx[32] |=> mval_ff != $past(mval_ff) + 32'(step_ff))
    else $error("wrap did not load a limit");
endmodule : dpc_top

// ### tb/dpc_link_model.sv
// Far side of the telegram port: a bus link that takes telegrams.
// Assumes tel stands with tel_valid until the handshake edge.
`timescale 1ns/100ps
module dpc_link_model
  import dpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dpc_tel_t tel,
  input wire logic tel_valid,
  input wire logic slow,
  output logic tel_ready,
  output dpc_tel_t last_tel,
  output logic [15:0] tel_count
);
  logic [1:0] wait_ff;

  // One telegram per handshake; slow mode makes the sender hold its offer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tel_ready <= 1'b0;
      last_tel <= '0;
      tel_count <= 16'h0;
      wait_ff <= 2'h0;
    end
    else if (tel_valid && tel_ready)
    begin
      last_tel <= tel;
      tel_count <= tel_count + 16'h1;
      tel_ready <= 1'b0;
      wait_ff <= 2'h0;
    end
    else if (tel_valid && (!slow || wait_ff == 2'h3))
      tel_ready <= 1'b1;
    else if (tel_valid)
      wait_ff <= wait_ff + 2'h1;
  end
endmodule : dpc_link_model

// ### tb/tb_top.sv
// Self-checking bench for one pulse counter channel.
// Assumes zero-wait APB and the link model beside it.
`timescale 1ns/100ps
`include "dpc_params.svh"
module tb_top;
  import dpc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic in_pulse, in_level, manual_pulse, bus_recover, tel_valid, tel_ready, slow, e;
  dpc_tel_t tel, last_tel;
  logic [15:0] tel_count, tel_seen;
  int miscompares, total_checks, cycles;

  dpc_top #(.CHANNEL(0), .TICK_CYC(10), .SDLY_MS(2)) DUT (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_pulse, .in_level,
    .manual_pulse, .bus_recover, .tel, .tel_valid, .tel_ready);
  dpc_link_model LINK (.clk, .rst_n, .tel, .tel_valid, .slow, .tel_ready, .last_tel,
    .tel_count);

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits for the next telegram; none within the limit fails the compare
  task automatic ctel(input int ob, input logic [31:0] v);
    dpc_tel_t x;
    int n;
    logic late;
    x = '{obj: 7'(ob), len: 3'h1, data: v};
    n = 0;
    while (tel_count === tel_seen && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    late = (tel_count === tel_seen);
    tel_seen = tel_count;
    total_checks++;
    if (last_tel !== x || late)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, last_tel, x);
    end
  endtask : ctel

  // Request held until pready is seen at a rising edge
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xf(a, 1'b1, v);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] v);
    xf(a, 1'b0, 32'h0);
    chk(d, v);
  endtask : rchk

  task automatic ob(input int ofs, input logic v);
    wr(`DPC_A_OBJ, {23'h0, v, 1'b0, 7'(`DPC_OBJ_BASE + ofs)});
  endtask : ob

  // Pulses spaced five cycles so each count has landed
  task automatic pul(input int n, input logic man);
    repeat (n)
    begin
      @(posedge clk);
      in_pulse <= ~man;
      manual_pulse <= man;
      @(posedge clk);
      in_pulse <= 1'b0;
      manual_pulse <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : pul

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    in_pulse = 1'b0;
    in_level = 1'b0;
    manual_pulse = 1'b0;
    bus_recover = 1'b0;
    slow = 1'b0;
    tel_seen = 16'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`DPC_A_CTRL, 32'h0);
    rchk(`DPC_A_STEP, 32'h1);
    rchk(`DPC_A_DL1, 32'h0);
    rchk(`DPC_A_DL2, 32'hFF);
    xf(8'h40, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    $display("test reset done");
    // Wrap with both orders of the limits, which always differ
    for (int i = 0; i < 2; i++)
    begin
      wr(`DPC_A_ML1, (i == 1) ? 32'hA : 32'h0);
      wr(`DPC_A_ML2, (i == 1) ? 32'h0 : 32'hA);
      pul(10, 1'b0);
      rchk(`DPC_A_MVAL, 32'hA);
      pul(1, 1'b0);
      rchk(`DPC_A_MVAL, 32'h0);
      ctel(14, 32'h1);
    end
    $display("test wrap done");
    ob(0, 1'b1);
    xf(`DPC_A_STAT, 1'b0, 32'h0);
    chk({31'h0, d[0]}, 32'h1);
    pul(1, 1'b0);
    rchk(`DPC_A_MVAL, 32'h0);
    pul(1, 1'b1);
    rchk(`DPC_A_MVAL, 32'h1);
    @(posedge clk);
    in_level <= 1'b1;
    ob(0, 1'b0);
    rchk(`DPC_A_MVAL, 32'h2);
    pul(1, 1'b0);
    rchk(`DPC_A_MVAL, 32'h3);
    $display("test block done");
    wr(`DPC_A_DIV, 32'h3);
    pul(2, 1'b0);
    rchk(`DPC_A_MVAL, 32'h3);
    ob(0, 1'b1);
    pul(1, 1'b0);
    ob(0, 1'b0);
    rchk(`DPC_A_MVAL, 32'h3);
    pul(1, 1'b0);
    rchk(`DPC_A_MVAL, 32'h4);
    wr(`DPC_A_DIV, 32'h1);
    wr(`DPC_A_STEP, 32'h0000_4E20);
    rchk(`DPC_A_STEP, 32'h0000_2710);
    wr(`DPC_A_STEP, 32'hFFFF_FFFF);
    pul(5, 1'b0);
    rchk(`DPC_A_MVAL, 32'hA);
    ctel(14, 32'h1);
    $display("test step done");
    // Slow link: the telegram must stand until taken
    slow <= 1'b1;
    ob(3, 1'b0);
    repeat (30) @(posedge clk);
    chk({16'h0, tel_count}, {16'h0, tel_seen});
    ob(3, 1'b1);
    ctel(11, 32'hA);
    slow <= 1'b0;
    $display("test request done");
    wr(`DPC_A_ML1, 32'h0);
    wr(`DPC_A_ML2, 32'h64);
    wr(`DPC_A_STEP, 32'h1);
    wr(`DPC_A_CTRL, 32'h1);
    wr(`DPC_A_CRST, 32'h1);
    pul(2, 1'b0);
    rchk(`DPC_A_DVAL, 32'h2);
    ob(6, 1'b1);
    pul(1, 1'b0);
    rchk(`DPC_A_DVAL, 32'h1);
    ob(6, 1'b0);
    wr(`DPC_A_CTRL, 32'h5);
    pul(1, 1'b0);
    rchk(`DPC_A_DVAL, 32'h0);
    pul(1, 1'b0);
    rchk(`DPC_A_DVAL, 32'hFF);
    ctel(15, 32'h1);
    ob(7, 1'b1);
    rchk(`DPC_A_DVAL, 32'h0);
    ob(8, 1'b1);
    pul(1, 1'b0);
    rchk(`DPC_A_DVAL, 32'h0);
    rchk(`DPC_A_MVAL, 32'h6);
    ob(8, 1'b0);
    $display("test difference done");
    wr(`DPC_A_CTRL, 32'h7);
    pul(1, 1'b0);
    rchk(`DPC_A_DVAL, 32'h0);
    ctel(15, 32'h1);
    xf(`DPC_A_STAT, 1'b0, 32'h0);
    chk({31'h0, d[3]}, 32'h1);
    wr(`DPC_A_CRST, 32'h1);
    xf(`DPC_A_STAT, 1'b0, 32'h0);
    chk({31'h0, d[3]}, 32'h0);
    $display("test stop done");
    wr(`DPC_A_CTRL, 32'h8);
    @(posedge clk);
    bus_recover <= 1'b1;
    @(posedge clk);
    bus_recover <= 1'b0;
    ctel(11, 32'h0);
    $display("test recovery done");
    wr(`DPC_A_CTRL, 32'h20);
    pul(1, 1'b0);
    ctel(11, 32'h1);
    wr(`DPC_A_CYC, 32'h3);
    wr(`DPC_A_CTRL, 32'h80);
    ctel(11, 32'h1);
    ctel(11, 32'h1);
    $display("test send modes done");
    finish_test();
  end
endmodule : tb_top
